//--- core/bpc_regs.sv
// Control and status register bank of the battery protection chip
// Behaviour
// [RQ1] Control word volatile, written only by write-control
// [RQ2] Control word clears at power-up and sleep exit
// [RQ3] Host writes zero to bits 5,6
// [RQ4] Sleep bit requests sleep below threshold only
// [RQ5] Bits 9:8 select sense gain code
// [RQ6] Bit 10 one drives charge FET low
// [RQ7] Bit 11 one drives discharge FET low
// [RQ8] FET override changes deferred during protection
// [RQ9] Bits 12-15 drive balance outputs high
// [RQ10] Status byte bits 3-7 read zero
// [RQ11] Status bit 0 untuned OR overcurrent
// [RQ12] Status bit 1 shows over-discharge
// [RQ13] Charge enable on: bit 2 lowcell OR overcharge
// [RQ14] Charge enable off: bit 2 overcharge only
// [RQ15] Regulator status high until output tuned
// [RQ16] Charge enable selection from config bit 6
// [RQ17] Control word updates whole on completed write
// [RQ18] Status snapshot taken at read start
`timescale 1ns/1ps
`default_nettype none

module bpc_regs (
  input wire logic I_CLK,
  input wire logic I_RST,
  input wire logic I_WR_DONE,
  input wire logic [15:0] I_WR_DATA,
  input wire logic I_RD_START,
  input wire logic [15:0] I_CFG_WORD,
  input wire logic I_BELOW_SLEEP_THR,
  input wire logic I_REG_UNTUNED,
  input wire logic I_OVERCURRENT,
  input wire logic I_OVERDISCHARGE,
  input wire logic I_CELL_LOW,
  input wire logic I_OVERCHARGE,
  output logic [15:0] O_CTRL_WORD,
  output logic [7:0] O_STATUS,
  output logic O_SLEEP_REQ,
  output logic [1:0] O_SENSE_GAIN,
  output logic O_CHARGE_FET_DRIVE,
  output logic O_DISCHARGE_FET_DRIVE,
  output logic [3:0] O_BALANCE_OUT
);

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers for analog-side status levels
  logic below_thr_s;
  logic reg_untuned_s;
  logic overcurrent_s;
  logic overdischarge_s;
  logic cell_low_s;
  logic overcharge_s;

  bpc_sync u_sync_below_thr (
    .i_clk(I_CLK),
    .i_rst(I_RST),
    .i_d(I_BELOW_SLEEP_THR),
    .o_q(below_thr_s)
  );

  bpc_sync u_sync_reg_untuned (
    .i_clk(I_CLK),
    .i_rst(I_RST),
    .i_d(I_REG_UNTUNED),
    .o_q(reg_untuned_s)
  );

  bpc_sync u_sync_overcurrent (
    .i_clk(I_CLK),
    .i_rst(I_RST),
    .i_d(I_OVERCURRENT),
    .o_q(overcurrent_s)
  );

  bpc_sync u_sync_overdischarge (
    .i_clk(I_CLK),
    .i_rst(I_RST),
    .i_d(I_OVERDISCHARGE),
    .o_q(overdischarge_s)
  );

  bpc_sync u_sync_cell_low (
    .i_clk(I_CLK),
    .i_rst(I_RST),
    .i_d(I_CELL_LOW),
    .o_q(cell_low_s)
  );

  bpc_sync u_sync_overcharge (
    .i_clk(I_CLK),
    .i_rst(I_RST),
    .i_d(I_OVERCHARGE),
    .o_q(overcharge_s)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Synchronised protection levels
  bpc_pkg::bpc_prot_t prot;
  logic in_protect;

  always_comb begin
    prot.regulator_untuned = reg_untuned_s; // RQ15
    prot.overcurrent_active = overcurrent_s;
    prot.overdischarge_active = overdischarge_s;
    prot.cell_low_flag = cell_low_s;
    prot.overcharge_active = overcharge_s;
    in_protect = prot.overcharge_active | prot.overdischarge_active | prot.overcurrent_active; // RQ8
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control word
  logic [15:0] ctrl_q;
  logic [15:0] ctrl_d;

  always_comb begin
    ctrl_d = ctrl_q;
    if (I_WR_DONE) begin
      ctrl_d = I_WR_DATA; // RQ1 RQ17
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      ctrl_q <= bpc_pkg::CTRL_RESET; // RQ2
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sense gain code
  bpc_pkg::bpc_gain_t gain_q;
  bpc_pkg::bpc_gain_t gain_d;

  always_comb begin
    case (ctrl_d[bpc_pkg::BIT_GAIN_LO +: 2]) // RQ5
      2'h0: begin
        gain_d = bpc_pkg::BPC_GAIN_X10;
      end
      2'h1: begin
        gain_d = bpc_pkg::BPC_GAIN_X25;
      end
      2'h2: begin
        gain_d = bpc_pkg::BPC_GAIN_X80;
      end
      2'h3: begin
        gain_d = bpc_pkg::BPC_GAIN_X160;
      end
      default: begin
        gain_d = bpc_pkg::BPC_GAIN_X10;
      end
    endcase
  end

  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      gain_q <= bpc_pkg::BPC_GAIN_X10;
    end else begin
      gain_q <= gain_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Cell balance drives
  logic [3:0] bal_q;
  logic [3:0] bal_d;

  always_comb begin
    bal_d = ctrl_d[bpc_pkg::BIT_BAL_LO +: 4]; // RQ9
  end

  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      bal_q <= bpc_pkg::CTRL_RESET[bpc_pkg::BIT_BAL_LO +: 4];
    end else begin
      bal_q <= bal_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sleep request
  logic sleep_q;
  logic sleep_d;

  always_comb begin
    sleep_d = ctrl_q[bpc_pkg::BIT_SLEEP] & below_thr_s; // RQ4
  end

  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      sleep_q <= 1'h0;
    end else begin
      sleep_q <= sleep_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Charge FET drive, forced high on overcharge, held during other protection
  logic chg_fet_q;
  logic chg_fet_d;

  always_comb begin
    chg_fet_d = chg_fet_q;
    if (prot.overcharge_active) begin
      chg_fet_d = 1'h1;
    end else if (!in_protect) begin
      chg_fet_d = ~ctrl_q[bpc_pkg::BIT_CHG_OVR]; // RQ6 RQ8
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      chg_fet_q <= 1'h1;
    end else begin
      chg_fet_q <= chg_fet_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Discharge FET drive, forced high on overdischarge or overcurrent, held during overcharge
  logic dsg_fet_q;
  logic dsg_fet_d;

  always_comb begin
    dsg_fet_d = dsg_fet_q;
    if (prot.overdischarge_active | prot.overcurrent_active) begin
      dsg_fet_d = 1'h1;
    end else if (!in_protect) begin
      dsg_fet_d = ~ctrl_q[bpc_pkg::BIT_DSG_OVR]; // RQ7 RQ8
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      dsg_fet_q <= 1'h1;
    end else begin
      dsg_fet_q <= dsg_fet_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status snapshot
  logic cell_bit;
  logic [7:0] stat_q;
  logic [7:0] stat_d;

  always_comb begin
    if (I_CFG_WORD[bpc_pkg::CFG_CHG_EN_OFF_BIT]) begin // RQ16
      cell_bit = prot.overcharge_active; // RQ14
    end else begin
      cell_bit = prot.cell_low_flag | prot.overcharge_active; // RQ13
    end
    stat_d = stat_q;
    if (I_RD_START) begin
      stat_d = 8'h00; // RQ10 RQ18
      stat_d[bpc_pkg::STAT_BIT_REG_OC] = prot.regulator_untuned | prot.overcurrent_active; // RQ11
      stat_d[bpc_pkg::STAT_BIT_OVDIS] = prot.overdischarge_active; // RQ12
      stat_d[bpc_pkg::STAT_BIT_CELL_OC] = cell_bit;
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      stat_q <= 8'h00;
    end else begin
      stat_q <= stat_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  always_comb begin
    O_CTRL_WORD = ctrl_q;
    O_STATUS = stat_q;
    O_SLEEP_REQ = sleep_q;
    O_SENSE_GAIN = gain_q;
    O_CHARGE_FET_DRIVE = chg_fet_q;
    O_DISCHARGE_FET_DRIVE = dsg_fet_q;
    O_BALANCE_OUT = bal_q;
  end

endmodule

////////////////////////////////////////////////////////////////////////////////
// Two-stage synchroniser for one asynchronous level
module bpc_sync #(
  parameter logic RST_VAL = 1'h0
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_d,
  output logic o_q
);

  logic meta_q;
  logic meta_d;
  logic sync_q;
  logic sync_d;

  always_comb begin
    meta_d = i_d;
    sync_d = meta_q;
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      meta_q <= RST_VAL;
      sync_q <= RST_VAL;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  always_comb begin
    o_q = sync_q;
  end

endmodule

`default_nettype wire

//--- core/bpc_pkg.sv
// Package: control and status word layout for the protection register bank
package bpc_pkg;

  localparam int CTRL_W = 16;
  localparam int STAT_W = 8;
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam int BIT_SLEEP = 7;
  localparam int BIT_GAIN_LO = 8;
  localparam int BIT_CHG_OVR = 10;
  localparam int BIT_DSG_OVR = 11;
  localparam int BIT_BAL_LO = 12;
  localparam int CFG_CHG_EN_OFF_BIT = 6;
  localparam int STAT_BIT_REG_OC = 0;
  localparam int STAT_BIT_OVDIS = 1;
  localparam int STAT_BIT_CELL_OC = 2;

  // Gain select codes: x10, x25, x80, x160
  typedef enum logic [1:0] {
    BPC_GAIN_X10 = 2'h0,
    BPC_GAIN_X25 = 2'h1,
    BPC_GAIN_X80 = 2'h2,
    BPC_GAIN_X160 = 2'h3
  } bpc_gain_t;

  // Internal protection status signals
  typedef struct packed {
    logic regulator_untuned;
    logic overcurrent_active;
    logic overdischarge_active;
    logic cell_low_flag;
    logic overcharge_active;
  } bpc_prot_t;

endpackage

//--- test/bpc_host.sv
// Host model issuing write-control transfers
`timescale 1ns/1ps
`default_nettype none
module bpc_host (
  input wire logic i_clk,
  output logic o_wr_done,
  output logic [15:0] o_wr_data
);
  initial {o_wr_done, o_wr_data} = 17'h0;
  task automatic wr(input logic [15:0] d);
    @(negedge i_clk);
    o_wr_done = 1'b1;
    o_wr_data = d & 16'hff9f;
    @(negedge i_clk);
    o_wr_done = 1'b0;
  endtask
endmodule
`default_nettype wire

//--- test/bpc_regs_sva.sv
// Port assertions for the register bank
`timescale 1ns/1ps
`default_nettype none
module bpc_regs_sva (
  input wire logic I_CLK,
  input wire logic I_RST,
  input wire logic I_WR_DONE,
  input wire logic [15:0] I_WR_DATA,
  input wire logic I_RD_START,
  input wire logic I_OVERDISCHARGE,
  input wire logic I_OVERCHARGE,
  input wire logic [15:0] O_CTRL_WORD,
  input wire logic [7:0] O_STATUS,
  input wire logic [1:0] O_SENSE_GAIN,
  input wire logic O_CHARGE_FET_DRIVE,
  input wire logic O_DISCHARGE_FET_DRIVE,
  input wire logic [3:0] O_BALANCE_OUT
);
  default clocking @(posedge I_CLK); endclocking
  default disable iff (I_RST);
  a_ctrl_load: assert property (I_WR_DONE |=> O_CTRL_WORD == $past(I_WR_DATA)) else $error("load");
  a_ctrl_hold: assert property (!I_WR_DONE |=> $stable(O_CTRL_WORD)) else $error("hold");
  a_gain_sel: assert property (I_WR_DONE |=> O_SENSE_GAIN == $past(I_WR_DATA[9:8])) else $error("gain");
  a_bal_out: assert property (I_WR_DONE |=> O_BALANCE_OUT == $past(I_WR_DATA[15:12])) else $error("bal");
  a_chg_force: assert property (I_OVERCHARGE [*3] |=> O_CHARGE_FET_DRIVE) else $error("chg");
  a_dsg_force: assert property (I_OVERDISCHARGE [*3] |=> O_DISCHARGE_FET_DRIVE) else $error("dsg");
  a_stat_zero: assert property (O_STATUS[7:3] == 5'h00) else $error("zero");
  a_stat_hold: assert property (!I_RD_START |=> $stable(O_STATUS)) else $error("snap");
endmodule
bind bpc_regs bpc_regs_sva u_sva (
  .I_CLK(I_CLK),
  .I_RST(I_RST),
  .I_WR_DONE(I_WR_DONE),
  .I_WR_DATA(I_WR_DATA),
  .I_RD_START(I_RD_START),
  .I_OVERDISCHARGE(I_OVERDISCHARGE),
  .I_OVERCHARGE(I_OVERCHARGE),
  .O_CTRL_WORD(O_CTRL_WORD),
  .O_STATUS(O_STATUS),
  .O_SENSE_GAIN(O_SENSE_GAIN),
  .O_CHARGE_FET_DRIVE(O_CHARGE_FET_DRIVE),
  .O_DISCHARGE_FET_DRIVE(O_DISCHARGE_FET_DRIVE),
  .O_BALANCE_OUT(O_BALANCE_OUT)
);
`default_nettype wire

//--- test/tb_top.sv
// Testbench for the register bank
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk = 1'b0, rst = 1'b1, rd = 1'b0, thr = 1'b0, wd, sleep_select, cf, df;
  logic [15:0] cfg = 16'h0000, wdat, ctrl;
  logic [4:0] p = 5'h00;
  logic [7:0] st;
  logic [1:0] g;
  logic [3:0] bal;
  int fails = 0, n_compared = 0;
  always #5 clk = ~clk;
  bpc_host u_host (.i_clk(clk), .o_wr_done(wd), .o_wr_data(wdat));
  bpc_regs DUT (.I_CLK(clk), .I_RST(rst), .I_WR_DONE(wd), .I_WR_DATA(wdat), .I_RD_START(rd), .I_CFG_WORD(cfg),
    .I_BELOW_SLEEP_THR(thr), .I_REG_UNTUNED(p[4]), .I_OVERCURRENT(p[3]), .I_OVERDISCHARGE(p[2]),
    .I_CELL_LOW(p[1]), .I_OVERCHARGE(p[0]), .O_CTRL_WORD(ctrl), .O_STATUS(st), .O_SLEEP_REQ(sleep_select),
    .O_SENSE_GAIN(g), .O_CHARGE_FET_DRIVE(cf), .O_DISCHARGE_FET_DRIVE(df), .O_BALANCE_OUT(bal));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %0t %h %h", $time, got, exp);
    end
  endtask
  task automatic conclude();
    $display("fails %0d n_compared %0d", fails, n_compared);
    if (fails == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic wn(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic rds(input logic [4:0] v, input logic [7:0] e);
    p = v;
    wn(3);
    rd = 1'b1;
    wn(1);
    rd = 1'b0;
    wn(1);
    chk(st, e);
  endtask
  initial begin
    wn(20);
    rst = 1'b0;
    chk({ctrl, cf, df}, 18'h3);
    for (int i = 0; i < 4; i++) begin
      u_host.wr({4'h1 << i, i[0], ~i[0], i[1:0], 8'he0});
      wn(2);
      chk(ctrl, {4'h1 << i, i[0], ~i[0], i[1:0], 8'h80});
      chk({bal, g, cf, df, sleep_select}, {4'h1 << i, i[1:0], i[0], ~i[0], 1'b0});
    end
    thr = 1'b1;
    wn(4);
    chk(sleep_select, 1'b1);
    p = 5'h04;
    wn(4);
    u_host.wr(16'h0c00);
    wn(4);
    chk({cf, df}, 16'h0003);
    p = 5'h00;
    wn(5);
    chk({cf, df}, 16'h0000);
    rds(5'h10, 8'h01);
    rds(5'h08, 8'h01);
    rds(5'h04, 8'h02);
    rds(5'h02, 8'h04);
    cfg = 16'h0040;
    rds(5'h02, 8'h00);
    rds(5'h1f, 8'h07);
    p = 5'h00;
    wn(4);
    chk(st, 8'h07);
    rst = 1'b1;
    wn(2);
    rst = 1'b0;
    chk({ctrl, cf, df}, 18'h3);
    conclude();
  end
endmodule
`default_nettype wire
